// File: lsfh_pkg.sv
package lsfh_pkg;

   // ************************************************************
   // Register addresses (register index, 8-bit address space)
   // ************************************************************
   localparam int unsigned ADDR_WIDTH             = 8;
   localparam int unsigned DATA_WIDTH             = 16;
   localparam logic [7:0]  OC_IRQ_STATUS_ADDR     = 8'h1D;
   localparam logic [7:0]  OC_IRQ_MASK_ADDR       = 8'h25;
   localparam logic [7:0]  SWITCH_CONTROL_ADDR    = 8'hC7;
   localparam logic [7:0]  SUPPLY_FAULT_CFG_ADDR  = 8'hD7;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned SWITCH_OC_FLAG_BIT     = 15;
   localparam int unsigned SWITCH_OC_MASK_BIT     = 15;
   localparam int unsigned SWITCH_FAULT_MASK_BIT  = 15;
   localparam int unsigned RESPONSE_SEL_HI        = 15;
   localparam int unsigned RESPONSE_SEL_LO        = 14;
   localparam int unsigned BULK_HIB_BIT           = 1;
   localparam int unsigned BULK_ACTIVE_BIT        = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] OC_IRQ_MASK_RESET      = 16'h0000;
   localparam logic [15:0] SWITCH_CONTROL_RESET   = 16'h0003;
   localparam logic [15:0] SUPPLY_FAULT_RESET     = 16'h0000;
   localparam logic [15:0] READ_ZERO              = 16'h0000;

   // ************************************************************
   // Response codes and filter timing
   // ************************************************************
   typedef enum logic [1:0] {
      LSFH_RESP_IGNORE   = 2'h0,
      LSFH_RESP_OPEN     = 2'h1,
      LSFH_RESP_SHUTDOWN = 2'h2,
      LSFH_RESP_SHUT_ALT = 2'h3
   } lsfh_resp_type;

   localparam int unsigned CLOCK_MHZ              = 125;
   localparam int unsigned FILTER_TIME_NS         = 1000;
   localparam int unsigned FILTER_CYCLES          = (FILTER_TIME_NS * CLOCK_MHZ + 999) / 1000;

endpackage : lsfh_pkg

// File: lsfh_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for an asynchronous level
module lsfh_sync (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // The first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : lsfh_sync

// File: lsfh_filter.sv
`timescale 1ns/1ps
// Persistence filter: output rises only after COUNT consecutive high samples
module lsfh_filter #(
   parameter int unsigned COUNT = lsfh_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Raw and filtered level
   input  wire logic raw_in,
   output logic      confirmed
);
   localparam int unsigned CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] count_q;

   // Count while high; any low sample restarts the wait
   always_ff @(posedge clock) begin
      if (reset) begin
         count_q   <= '0;
         confirmed <= 1'b0;
      end else if (!raw_in) begin
         count_q   <= '0;
         confirmed <= 1'b0;
      end else if (count_q >= LAST) begin
         confirmed <= 1'b1;
      end else begin
         count_q   <= count_q + 1'b1;
      end
   end
endmodule : lsfh_filter

// File: lsfh_top.sv
// Overview of operation
// - Confirmed over-current: response 00 none, 01 opens switch, 10/11 request shutdown.
// - Only persistent over-current counts; short surges raise nothing at all.
// - The first-level over-current interrupt has the switch flag as only source.
// - Flag is bit 15 of status, set on rising edge of filtered fault.
// - Reading the status register clears the flag.
// - Mask bit 15 set keeps the flag from raising the first-level interrupt.
// - Supply-fault output low while any supply or switch fault, else high.
// - Config bit 15 set masks the switch fault from the supply-fault output.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module lsfh_top #(
   parameter int unsigned FILTER_COUNT = lsfh_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            reset,
   // Register port
   input  wire logic [lsfh_pkg::ADDR_WIDTH-1:0] reg_addr,
   input  wire logic [lsfh_pkg::DATA_WIDTH-1:0] reg_wdata,
   input  wire logic                            reg_write,
   input  wire logic                            reg_read,
   output logic      [lsfh_pkg::DATA_WIDTH-1:0] reg_rdata,
   // Analogue monitor and other supply faults
   input  wire logic                            overcurrent_raw,
   input  wire logic                            other_supply_fault,
   // Responses
   output logic                                 switch_open_req,
   output logic                                 shutdown_req,
   output logic                                 supply_fault_n,
   output logic                                 overcurrent_top_irq
);

   // ************************************************************
   // Registers and internal signals
   // ************************************************************
   logic        oc_sync;
   logic        oc_confirmed;
   logic        oc_confirmed_q;
   logic        oc_rise;
   logic        other_fault_sync;
   logic        switch_overcurrent_flag_q;
   logic        switch_overcurrent_irq_mask_q;
   logic [15:0] switch_control_q;
   logic        switch_fault_output_mask_q;
   logic        status_read;
   logic [1:0]  overcurrent_response_sel;

   assign overcurrent_response_sel =
      switch_control_q[lsfh_pkg::RESPONSE_SEL_HI:lsfh_pkg::RESPONSE_SEL_LO];

   // ************************************************************
   // Input conditioning
   // ************************************************************
   // Both fault inputs come from analogue comparators, so synchronise first
   lsfh_sync u_sync_oc (
      .clock    (clock),
      .reset    (reset),
      .async_in (overcurrent_raw),
      .sync_out (oc_sync)
   );

   lsfh_sync u_sync_other (
      .clock    (clock),
      .reset    (reset),
      .async_in (other_supply_fault),
      .sync_out (other_fault_sync)
   );

   // Persistence filter hides surges shorter than the filter time
   lsfh_filter #(
      .COUNT (FILTER_COUNT)
   ) u_filter (
      .clock     (clock),
      .reset     (reset),
      .raw_in    (oc_sync),
      .confirmed (oc_confirmed)
   );

   // Edge detect on the confirmed fault
   always_ff @(posedge clock) begin
      if (reset) begin
         oc_confirmed_q <= 1'b0;
      end else begin
         oc_confirmed_q <= oc_confirmed;
      end
   end

   assign oc_rise     = oc_confirmed && !oc_confirmed_q;
   assign status_read = reg_read && (reg_addr == lsfh_pkg::OC_IRQ_STATUS_ADDR);

   // ************************************************************
   // Interrupt flag
   // ************************************************************
   // A new edge in the read cycle survives, so no event is lost
   always_ff @(posedge clock) begin
      if (reset) begin
         switch_overcurrent_flag_q <= 1'b0;
      end else if (oc_rise) begin
         switch_overcurrent_flag_q <= 1'b1;
      end else if (status_read) begin
         switch_overcurrent_flag_q <= 1'b0;
      end
   end

   // Only the switch flag feeds the top-level line
   assign overcurrent_top_irq =
      switch_overcurrent_flag_q && !switch_overcurrent_irq_mask_q;

   // ************************************************************
   // Software writable registers
   // ************************************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         switch_overcurrent_irq_mask_q <= lsfh_pkg::OC_IRQ_MASK_RESET[lsfh_pkg::SWITCH_OC_MASK_BIT];
         switch_control_q              <= lsfh_pkg::SWITCH_CONTROL_RESET;
         switch_fault_output_mask_q    <= lsfh_pkg::SUPPLY_FAULT_RESET[lsfh_pkg::SWITCH_FAULT_MASK_BIT];
      end else if (reg_write) begin
         case (reg_addr)
            lsfh_pkg::OC_IRQ_MASK_ADDR: begin
               switch_overcurrent_irq_mask_q <= reg_wdata[lsfh_pkg::SWITCH_OC_MASK_BIT];
            end
            lsfh_pkg::SWITCH_CONTROL_ADDR: begin
               switch_control_q <= reg_wdata;
            end
            lsfh_pkg::SUPPLY_FAULT_CFG_ADDR: begin
               switch_fault_output_mask_q <= reg_wdata[lsfh_pkg::SWITCH_FAULT_MASK_BIT];
            end
            default: begin
               // Unmapped or read-only: write ignored
            end
         endcase
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   // Data stand only in the cycle after the strobe; zero otherwise
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= lsfh_pkg::READ_ZERO;
      end else if (reg_read) begin
         reg_rdata <= lsfh_pkg::READ_ZERO;
         case (reg_addr)
            lsfh_pkg::OC_IRQ_STATUS_ADDR: begin
               reg_rdata[lsfh_pkg::SWITCH_OC_FLAG_BIT] <= switch_overcurrent_flag_q;
            end
            lsfh_pkg::OC_IRQ_MASK_ADDR: begin
               reg_rdata[lsfh_pkg::SWITCH_OC_MASK_BIT] <= switch_overcurrent_irq_mask_q;
            end
            lsfh_pkg::SWITCH_CONTROL_ADDR: begin
               reg_rdata <= switch_control_q;
            end
            lsfh_pkg::SUPPLY_FAULT_CFG_ADDR: begin
               reg_rdata[lsfh_pkg::SWITCH_FAULT_MASK_BIT] <= switch_fault_output_mask_q;
            end
            default: begin
               reg_rdata <= lsfh_pkg::READ_ZERO;
            end
         endcase
      end else begin
         reg_rdata <= lsfh_pkg::READ_ZERO;
      end
   end

   // ************************************************************
   // Fault response
   // ************************************************************
   // Requests are levels held while the confirmed fault lasts; the
   // power sequencer latches them, so a short hold is enough
   always_ff @(posedge clock) begin
      if (reset) begin
         switch_open_req <= 1'b0;
         shutdown_req    <= 1'b0;
      end else begin
         switch_open_req <= 1'b0;
         shutdown_req    <= 1'b0;
         if (oc_confirmed) begin
            case (overcurrent_response_sel)
               lsfh_pkg::LSFH_RESP_IGNORE: begin
                  switch_open_req <= 1'b0;
               end
               lsfh_pkg::LSFH_RESP_OPEN: begin
                  switch_open_req <= 1'b1;
               end
               default: begin
                  shutdown_req    <= 1'b1;
               end
            endcase
         end
      end
   end

   // Supply-fault pin, active low, registered
   always_ff @(posedge clock) begin
      if (reset) begin
         supply_fault_n <= 1'b1;
      end else begin
         supply_fault_n <= !(other_fault_sync ||
                             (oc_confirmed && !switch_fault_output_mask_q));
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   // Disabled in reset: the synchronisers need two edges to refill after it
   a_irq_follows_flag: assert property (@(posedge clock) disable iff (reset)
      oc_rise && !switch_overcurrent_irq_mask_q ##1 !switch_overcurrent_irq_mask_q
         |-> overcurrent_top_irq)
      else $error("interrupt does not follow flag and mask");

   a_mask_blocks_irq: assert property (@(posedge clock) disable iff (reset)
      switch_overcurrent_irq_mask_q |-> !overcurrent_top_irq)
      else $error("masked flag raised interrupt");

   a_flag_on_edge: assert property (@(posedge clock) disable iff (reset)
      oc_confirmed && !oc_confirmed_q |=> switch_overcurrent_flag_q)
      else $error("flag not set on fault edge");

   a_flag_needs_edge: assert property (@(posedge clock) disable iff (reset)
      $rose(switch_overcurrent_flag_q) |-> $past(oc_rise))
      else $error("flag set without fault edge");

   a_read_clears_flag: assert property (@(posedge clock) disable iff (reset)
      status_read && !oc_rise |=> !switch_overcurrent_flag_q)
      else $error("status read did not clear flag");

   a_read_shows_flag: assert property (@(posedge clock) disable iff (reset)
      status_read |=> reg_rdata[lsfh_pkg::SWITCH_OC_FLAG_BIT] == $past(switch_overcurrent_flag_q))
      else $error("status read data wrong");

   a_surge_filtered: assert property (@(posedge clock) disable iff (reset)
      !oc_sync |=> !oc_confirmed)
      else $error("fault confirmed after low sample");

   a_open_response: assert property (@(posedge clock) disable iff (reset)
      oc_confirmed && overcurrent_response_sel == lsfh_pkg::LSFH_RESP_OPEN
         |=> switch_open_req && !shutdown_req)
      else $error("open response missing");

   a_shutdown_response: assert property (@(posedge clock) disable iff (reset)
      oc_confirmed && overcurrent_response_sel[1] |=> shutdown_req && !switch_open_req)
      else $error("shutdown response missing");

   a_ignore_response: assert property (@(posedge clock) disable iff (reset)
      overcurrent_response_sel == lsfh_pkg::LSFH_RESP_IGNORE
         |=> !switch_open_req && !shutdown_req)
      else $error("ignore response acted");

   a_fault_pin_low: assert property (@(posedge clock) disable iff (reset)
      oc_confirmed && !switch_fault_output_mask_q |=> !supply_fault_n)
      else $error("supply fault pin not low");

   a_fault_pin_mask: assert property (@(posedge clock) disable iff (reset)
      switch_fault_output_mask_q && !other_fault_sync |=> supply_fault_n)
      else $error("masked switch fault reached pin");

   a_irq_drops_read: assert property (@(posedge clock) disable iff (reset)
      status_read && !oc_rise |=> !overcurrent_top_irq)
      else $error("interrupt stayed up after status read");

   a_flag_sticky: assert property (@(posedge clock) disable iff (reset)
      switch_overcurrent_flag_q && !status_read |=> switch_overcurrent_flag_q)
      else $error("flag lost without status read");

   a_set_beats_clear: assert property (@(posedge clock) disable iff (reset)
      oc_rise && status_read |=> switch_overcurrent_flag_q)
      else $error("edge in read cycle was lost");

   a_irq_single_source: assert property (@(posedge clock) disable iff (reset)
      overcurrent_top_irq |-> switch_overcurrent_flag_q)
      else $error("interrupt without switch flag");

   a_requests_exclusive: assert property (@(posedge clock) disable iff (reset)
      !(switch_open_req && shutdown_req))
      else $error("open and shutdown requested together");

   a_requests_need_fault: assert property (@(posedge clock) disable iff (reset)
      !oc_confirmed |=> !switch_open_req && !shutdown_req)
      else $error("response without confirmed fault");

   a_confirm_needs_high: assert property (@(posedge clock) disable iff (reset)
      $rose(oc_confirmed) |-> $past(oc_sync))
      else $error("fault confirmed without high sample");

   a_pin_high_idle: assert property (@(posedge clock) disable iff (reset)
      !oc_confirmed && !other_fault_sync |=> supply_fault_n)
      else $error("supply fault pin low without fault");

   a_other_fault_pin: assert property (@(posedge clock) disable iff (reset)
      other_fault_sync |=> !supply_fault_n)
      else $error("other supply fault missed pin");

   // Main scenarios: interrupt, read-clear, both responses, pin low
   c_irq_raised: cover property (@(posedge clock) disable iff (reset)
      $rose(overcurrent_top_irq));
   c_read_clear: cover property (@(posedge clock) disable iff (reset)
      switch_overcurrent_flag_q && status_read);
   c_shutdown: cover property (@(posedge clock) disable iff (reset)
      $rose(shutdown_req));
   c_pin_low: cover property (@(posedge clock) disable iff (reset)
      $fell(supply_fault_n));
   c_open_req: cover property (@(posedge clock) disable iff (reset)
      $rose(switch_open_req));

endmodule : lsfh_top

// File: lsfh_top_tb.sv
`timescale 1ns/1ps
module lsfh_top_tb;

   // ************************************************************
   // Signals and case table
   // ************************************************************
   localparam int unsigned FILT = 4;  // Short filter keeps the run brief
   typedef struct packed {
      logic [1:0] resp;
      logic       irq_mask;
      logic       sf_mask;
      logic [3:0] expect_out;  // open, shutdown, supply_fault_n, irq
   } lsfh_row_type;

   logic        clock;
   logic        reset;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [15:0] reg_rdata;
   logic        overcurrent_raw;
   logic        other_supply_fault;
   logic        switch_open_req;
   logic        shutdown_req;
   logic        supply_fault_n;
   logic        overcurrent_top_irq;
   int          fails;
   int          n_compared;
   lsfh_row_type rows [5] = '{
      '{2'h0, 1'b0, 1'b0, 4'h1}, '{2'h1, 1'b0, 1'b0, 4'h9}, '{2'h2, 1'b0, 1'b0, 4'h5},
      '{2'h3, 1'b0, 1'b0, 4'h5}, '{2'h1, 1'b1, 1'b1, 4'hA}};

   lsfh_top #(.FILTER_COUNT(FILT)) uut (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .overcurrent_raw(overcurrent_raw), .other_supply_fault(other_supply_fault),
      .switch_open_req(switch_open_req), .shutdown_req(shutdown_req),
      .supply_fault_n(supply_fault_n), .overcurrent_top_irq(overcurrent_top_irq));

   // ************************************************************
   // Clock, bus tasks and checks
   // ************************************************************
   // Free-running 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the taking edge
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd

   task automatic wait_out(input int n, input logic [3:0] exp);
      repeat (n) @(posedge clock);
      #1 chk({switch_open_req, shutdown_req, supply_fault_n, overcurrent_top_irq}, exp);
   endtask : wait_out

   task automatic pulse(input int n);
      @(posedge clock);
      overcurrent_raw <= 1'b1;
      repeat (n) @(posedge clock);
      overcurrent_raw <= 1'b0;
   endtask : pulse

   task automatic wrap_up;
      $display("compared %0d, fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      wrap_up();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      fails = 0;
      n_compared = 0;
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      overcurrent_raw = 1'b0;
      other_supply_fault = 1'b0;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      // Reset values, then the idle outputs
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
      rd(lsfh_pkg::OC_IRQ_MASK_ADDR, 16'h0000);
      rd(lsfh_pkg::SWITCH_CONTROL_ADDR, 16'h0003);
      rd(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, 16'h0000);
      wait_out(1, 4'h2);
      // Table cases: each response code with its masks
      foreach (rows[i]) begin
         wr(lsfh_pkg::SWITCH_CONTROL_ADDR, {rows[i].resp, 14'h0003});
         wr(lsfh_pkg::OC_IRQ_MASK_ADDR, {rows[i].irq_mask, 15'h0000});
         wr(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, {rows[i].sf_mask, 15'h0000});
         @(posedge clock);
         overcurrent_raw <= 1'b1;
         wait_out(12, rows[i].expect_out);
         rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h8000);
         rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
         wait_out(0, {rows[i].expect_out[3:1], 1'b0});
         @(posedge clock);
         overcurrent_raw <= 1'b0;
         wait_out(12, 4'h2);
      end
      // Surge one cycle short of the filter: nothing at all appears
      wr(lsfh_pkg::OC_IRQ_MASK_ADDR, 16'h0000);
      wr(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, 16'h0000);
      wr(lsfh_pkg::SWITCH_CONTROL_ADDR, 16'h8003);
      pulse(FILT - 1);
      for (int k = 0; k < 12; k++) wait_out(1, 4'h2);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
      // Exactly the filter length is confirmed
      pulse(FILT);
      wait_out(12, 4'h3);
      // Masking drops the interrupt, unmasking restores it, a read clears it
      wr(lsfh_pkg::OC_IRQ_MASK_ADDR, 16'hFFFF);
      wait_out(0, 4'h2);
      rd(lsfh_pkg::OC_IRQ_MASK_ADDR, 16'h8000);
      wr(lsfh_pkg::OC_IRQ_MASK_ADDR, 16'h0000);
      wait_out(0, 4'h3);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h8000);
      wait_out(1, 4'h2);
      chk(reg_rdata, 16'h0000);
      // Other supplies still pull the pin low with the switch share masked
      wr(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, 16'hFFFF);
      rd(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, 16'h8000);
      @(posedge clock);
      other_supply_fault <= 1'b1;
      wait_out(6, 4'h0);
      @(posedge clock);
      other_supply_fault <= 1'b0;
      wait_out(6, 4'h2);
      // Status is not writable; unmapped reads give zero
      wr(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'hFFFF);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
      wr(8'h40, 16'hA5A5);
      rd(8'h40, 16'h0000);
      rd(lsfh_pkg::SWITCH_CONTROL_ADDR, 16'h8003);
      // Mid-run reset with the flag set returns status, supply-fault config and switch control to reset
      pulse(FILT);
      wait_out(12, 4'h3);
      @(posedge clock);
      reset <= 1'b1;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      wait_out(0, 4'h2);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
      rd(lsfh_pkg::SUPPLY_FAULT_CFG_ADDR, 16'h0000);
      rd(lsfh_pkg::SWITCH_CONTROL_ADDR, 16'h0003);
      // A status read in the very cycle of a new edge keeps the flag
      @(posedge clock);
      overcurrent_raw <= 1'b1;
      repeat (FILT + 2) @(posedge clock);
      reg_addr <= lsfh_pkg::OC_IRQ_STATUS_ADDR;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read        <= 1'b0;
      overcurrent_raw <= 1'b0;
      #1 chk(reg_rdata, 16'h0000);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h8000);
      rd(lsfh_pkg::OC_IRQ_STATUS_ADDR, 16'h0000);
      wrap_up();
   end

endmodule : lsfh_top_tb
